// ### cca_counter_array.sv
// Purpose: Counter array: 16-bit counter, timebase, overflow, five capture/compare modules.
// Assumes: APB slave; answer in the second access cycle; pins are asynchronous.
// Notes:   Watchdog reset generation, frequency output and modulators are elsewhere.
//
// The placing of the registers and register access over APB are this design's own decisions.

`timescale 1ns/1ps

module cca_counter_array #(
   parameter int NUM_MOD = 5 // Number of capture/compare modules
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cca_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_idle,
   input wire logic timer0_overflow,
   input wire logic external_count_input,
   input wire logic external_oscillator,
   input wire logic [NUM_MOD-1:0] module_pin,
   output logic [NUM_MOD-1:0] module_out,
   output logic irq
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [15:0] cnt_q; // The counter
   logic [7:0] snap_q; // High byte snapshot
   logic [7:0] mode_reg_q; // Array mode register
   logic [7:0] ctrl_q; // Flags and run bit
   logic [1:0] ie_q; // Global and array interrupt enables
   logic step_q; // Counter moved last edge
   logic [3:0] pre12_q; // Divide-by-12 prescaler
   logic [1:0] pre4_q; // Divide-by-4 prescaler
   logic [2:0] osc_div_q; // Oscillator edge divider
   logic e1_q, e2_q, e3_q; // Count input sync
   logic o1_q, o2_q, o3_q; // Oscillator sync
   logic tick, advance, wd_on, suspended;
   logic data_phase, done, wr, rd_take;
   logic [7:0] wbyte, rbyte;
   logic hit;
   logic [NUM_MOD-1:0] wr_mode_v, wr_low_v, wr_high_v, evt_v, pin_v, irq_en_v;
   logic [7:0] mm_v [NUM_MOD];
   logic [15:0] ccr_v [NUM_MOD];

   // Byte address of module register i in a bank
   function automatic logic [7:0] mod_addr(input logic [7:0] base, input int i);
      return base + 8'(i * 4);
   endfunction : mod_addr

   // ----------------------------------------------------------------
   // APB handshake
   // ----------------------------------------------------------------
   assign data_phase = psel && penable && !pready;
   assign done = psel && penable && pready;
   assign wr = done && pwrite; // Writes land on the completing edge
   assign rd_take = data_phase && !pwrite;
   assign wbyte = pwdata[7:0];

   // One wait cycle keeps read data registered
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= data_phase;
         if (data_phase) begin
            pslverr <= !hit; // Unmapped offset answers with an error
            prdata <= {24'h00_0000, pwrite ? 8'h00 : rbyte};
         end
      end
   end

   // ----------------------------------------------------------------
   // Address decode and read mux
   // ----------------------------------------------------------------
   // Reads are pure muxes: nothing here touches the counter
   always_comb begin
      hit = 1'b1;
      rbyte = 8'h00;
      wr_mode_v = '0;
      wr_low_v = '0;
      wr_high_v = '0;
      case (paddr)
         cca_pkg::OFF_CNT_LOW: rbyte = cnt_q[7:0];
         cca_pkg::OFF_CNT_HIGH: rbyte = snap_q;
         cca_pkg::OFF_MODE: rbyte = mode_reg_q;
         cca_pkg::OFF_CTRL: rbyte = ctrl_q;
         cca_pkg::OFF_IRQ: rbyte = {6'h00, ie_q};
         cca_pkg::OFF_PINS: rbyte = 8'(pin_v);
         default: hit = 1'b0;
      endcase
      for (int i = 0; i < NUM_MOD; i++) begin
         if (paddr == mod_addr(cca_pkg::OFF_MM_BASE, i)) begin
            hit = 1'b1;
            rbyte = mm_v[i];
            // Watchdog module refuses mode writes while the watchdog runs; low/high byte writes still clear/set its comparator enable
            wr_mode_v[i] = wr && !(wd_on && i == cca_pkg::WD_MODULE);
         end
         if (paddr == mod_addr(cca_pkg::OFF_CL_BASE, i)) begin
            hit = 1'b1;
            rbyte = ccr_v[i][7:0];
            wr_low_v[i] = wr;
         end
         if (paddr == mod_addr(cca_pkg::OFF_CH_BASE, i)) begin
            hit = 1'b1;
            rbyte = ccr_v[i][15:8];
            wr_high_v[i] = wr;
         end
      end
   end

   // Snapshot taken with the low byte's read data
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         snap_q <= 8'h00;
      end else if (rd_take && paddr == cca_pkg::OFF_CNT_LOW) begin
         snap_q <= cnt_q[15:8];
      end
   end

   // ----------------------------------------------------------------
   // Mode, enable and control registers
   // ----------------------------------------------------------------
   assign wd_on = mode_reg_q[cca_pkg::MD_WD];

   // Timebase and idle bits are frozen while the watchdog runs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mode_reg_q <= cca_pkg::MODE_RST; // Watchdog on after reset
      end else if (wr && paddr == cca_pkg::OFF_MODE) begin
         mode_reg_q[cca_pkg::MD_ECF] <= wbyte[cca_pkg::MD_ECF];
         mode_reg_q[cca_pkg::MD_WD] <= wbyte[cca_pkg::MD_WD];
         if (!wd_on) begin
            mode_reg_q[cca_pkg::MD_TB_LO +: 3] <= wbyte[cca_pkg::MD_TB_LO +: 3];
            mode_reg_q[cca_pkg::MD_IDLE] <= wbyte[cca_pkg::MD_IDLE];
         end
      end
   end

   // Interrupt enables
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ie_q <= 2'h0;
      end else if (wr && paddr == cca_pkg::OFF_IRQ) begin
         ie_q <= wbyte[1:0];
      end
   end

   // Flags: software write first, hardware set ORed after so a set wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_q <= 8'h00;
      end else begin
         if (wr && paddr == cca_pkg::OFF_CTRL) begin
            ctrl_q <= wbyte & 8'hdf; // Only software clears
         end
         if (advance && cnt_q == 16'hffff) begin
            ctrl_q[cca_pkg::CT_CF] <= 1'b1;
         end
         for (int i = 0; i < NUM_MOD; i++) begin
            if (evt_v[i]) begin
               ctrl_q[i] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Timebase
   // ----------------------------------------------------------------
   // External inputs pass two flops; third flop only for edge detect
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         e1_q <= 1'b0;
         e2_q <= 1'b0;
         e3_q <= 1'b0;
         o1_q <= 1'b0;
         o2_q <= 1'b0;
         o3_q <= 1'b0;
      end else begin
         e1_q <= external_count_input;
         e2_q <= e1_q;
         e3_q <= e2_q;
         o1_q <= external_oscillator;
         o2_q <= o1_q;
         o3_q <= o2_q;
      end
   end

   // Prescalers run freely; sources faster than sysclk/2 would alias
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pre12_q <= 4'h0;
         pre4_q <= 2'h0;
         osc_div_q <= 3'h0;
      end else begin
         pre12_q <= (pre12_q == cca_pkg::DIV12_LAST) ? 4'h0 : pre12_q + 4'h1;
         pre4_q <= pre4_q + 2'h1;
         if (o2_q && !o3_q) begin
            osc_div_q <= osc_div_q + 3'h1;
         end
      end
   end

   // Source select
   always_comb begin
      case (mode_reg_q[cca_pkg::MD_TB_LO +: 3])
         cca_pkg::TB_DIV12: tick = (pre12_q == cca_pkg::DIV12_LAST);
         cca_pkg::TB_DIV4: tick = (pre4_q == cca_pkg::DIV4_LAST);
         cca_pkg::TB_TMR0: tick = timer0_overflow;
         cca_pkg::TB_ECI: tick = e3_q && !e2_q; // Falling edge
         cca_pkg::TB_SYS: tick = 1'b1;
         cca_pkg::TB_OSC8: tick = o2_q && !o3_q && (osc_div_q == cca_pkg::OSC8_LAST);
         default: tick = 1'b0;
      endcase
   end

   // Idle only stops the count when suspend is chosen
   assign suspended = mode_reg_q[cca_pkg::MD_IDLE] && cpu_idle;
   // Watchdog forces the counter on
   assign advance = tick && (ctrl_q[cca_pkg::CT_RUN] || wd_on) && !suspended;

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // Software writes are refused while the watchdog runs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 16'h0000;
         step_q <= 1'b0;
      end else begin
         step_q <= advance;
         if (wr && !wd_on && paddr == cca_pkg::OFF_CNT_LOW) begin
            cnt_q[7:0] <= wbyte;
         end else if (wr && !wd_on && paddr == cca_pkg::OFF_CNT_HIGH) begin
            cnt_q[15:8] <= wbyte;
         end else if (advance) begin
            cnt_q <= cnt_q + 16'h0001; // Wraps from all ones to zero
         end
      end
   end

   // ----------------------------------------------------------------
   // Capture/compare modules
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
      // Each module owns its pin and register
      cca_cc_unit u_cc (
         .clk(clk),
         .reset(reset),
         .pin_raw(module_pin[g]),
         .count(cnt_q),
         .count_step(step_q),
         .wr_mode(wr_mode_v[g]),
         .wr_low(wr_low_v[g]),
         .wr_high(wr_high_v[g]),
         .wdata(wbyte),
         .mode_q(mm_v[g]),
         .ccr_q(ccr_v[g]),
         .event_q(evt_v[g]),
         .out_q(module_out[g]),
         .pin_level(pin_v[g])
      );
      assign irq_en_v[g] = mm_v[g][cca_pkg::MM_IRQ];
   end

   // ----------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------
   // The global and array enables both gate every source
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= ie_q[cca_pkg::IE_GLOBAL] && ie_q[cca_pkg::IE_ARRAY] &&
            ((ctrl_q[cca_pkg::CT_CF] && mode_reg_q[cca_pkg::MD_ECF]) ||
            (|(ctrl_q[NUM_MOD-1:0] & irq_en_v)));
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_snapshot;
      @(posedge clk) disable iff (reset)
      (rd_take && paddr == cca_pkg::OFF_CNT_LOW) |=> snap_q == $past(cnt_q[15:8]);
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("snapshot wrong");

   property p_overflow;
      @(posedge clk) disable iff (reset)
      (advance && cnt_q == 16'hffff && !wr) |=> ctrl_q[cca_pkg::CT_CF] && cnt_q == 16'h0000;
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow flag missed");

   property p_irq_gate;
      @(posedge clk) disable iff (reset)
      irq |-> $past(ie_q[cca_pkg::IE_GLOBAL] && ie_q[cca_pkg::IE_ARRAY]);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

   property p_flag_sticky;
      @(posedge clk) disable iff (reset)
      (ctrl_q[0] && !(wr && paddr == cca_pkg::OFF_CTRL)) |=> ctrl_q[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

   property p_idle_halt;
      @(posedge clk) disable iff (reset)
      (suspended && !wr) |=> cnt_q == $past(cnt_q);
   endproperty
   a_idle_halt: assert property (p_idle_halt) else $error("count moved in idle");

   property p_sys_count;
      @(posedge clk) disable iff (reset)
      (mode_reg_q[cca_pkg::MD_TB_LO +: 3] == cca_pkg::TB_SYS && !suspended && !wr &&
      (ctrl_q[cca_pkg::CT_RUN] || wd_on))
      |=> cnt_q == $past(cnt_q) + 16'h0001;
   endproperty
   a_sys_count: assert property (p_sys_count) else $error("count stalled");

   property p_div12;
      @(posedge clk) disable iff (reset)
      (mode_reg_q[cca_pkg::MD_TB_LO +: 3] == cca_pkg::TB_DIV12 && advance && !wr)
      |=> !advance [*8];
   endproperty
   a_div12: assert property (p_div12) else $error("divide by 12 too fast");

   property p_wd_lock;
      @(posedge clk) disable iff (reset)
      (wd_on && wr && paddr == cca_pkg::OFF_CNT_LOW && !advance) |=> cnt_q == $past(cnt_q);
   endproperty
   a_wd_lock: assert property (p_wd_lock) else $error("count written under watchdog");

endmodule : cca_counter_array

// ### cca_pkg.sv
// Purpose: Shared constants and types for the counter array with capture/compare modules.
// Assumes: APB slave with 32-bit data; every register is one aligned word, data in bits 7:0.
// Notes:   Offsets, field positions and the array mode reset value are named here; other reset values are literals in the modules.

package cca_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CNT_LOW = 8'h00; // Counter low byte
   localparam logic [7:0] OFF_CNT_HIGH = 8'h04; // Counter high byte (snapshot on read)
   localparam logic [7:0] OFF_MODE = 8'h08; // Array mode register
   localparam logic [7:0] OFF_CTRL = 8'h0c; // Array control register
   localparam logic [7:0] OFF_IRQ = 8'h10; // Global and array interrupt enables
   localparam logic [7:0] OFF_PINS = 8'h14; // Live module pin levels
   localparam logic [7:0] OFF_MM_BASE = 8'h20; // Module mode registers, one word each
   localparam logic [7:0] OFF_CL_BASE = 8'h40; // Capture/compare low bytes
   localparam logic [7:0] OFF_CH_BASE = 8'h60; // Capture/compare high bytes

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int MD_ECF = 0; // Overflow interrupt enable
   localparam int MD_TB_LO = 1; // Timebase select, 3 bits
   localparam int MD_WD = 6; // Module 4 watchdog enable
   localparam int MD_IDLE = 7; // Idle suspend
   localparam logic [7:0] MODE_RST = 8'h40; // Watchdog on, divide by 12
   localparam int CT_RUN = 6; // Counter run
   localparam int CT_CF = 7; // Counter overflow flag
   localparam int IE_GLOBAL = 0;
   localparam int IE_ARRAY = 1;
   localparam int MM_IRQ = 0; // Module interrupt enable
   localparam int MM_PWM = 1;
   localparam int MM_TOG = 2;
   localparam int MM_MAT = 3;
   localparam int MM_FALLING_CAPTURE_ENABLE = 4;
   localparam int MM_RISING_CAPTURE_ENABLE = 5;
   localparam int MM_COMPARATOR_ENABLE = 6;
   localparam int MM_WIDE = 7;
   localparam int WD_MODULE = 4; // Module that serves as watchdog

   // ----------------------------------------------------------------
   // Timebase codes and dividers
   // ----------------------------------------------------------------
   localparam logic [2:0] TB_DIV12 = 3'h0;
   localparam logic [2:0] TB_DIV4 = 3'h1;
   localparam logic [2:0] TB_TMR0 = 3'h2;
   localparam logic [2:0] TB_ECI = 3'h3;
   localparam logic [2:0] TB_SYS = 3'h4;
   localparam logic [2:0] TB_OSC8 = 3'h5;
   localparam logic [3:0] DIV12_LAST = 4'hb;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   localparam logic [2:0] OSC8_LAST = 3'h7;

   // Module operating modes
   typedef enum {MODE_OFF, MODE_CAPTURE, MODE_SWTIMER, MODE_HSO, MODE_FREQ,
      MODE_PWM8, MODE_WIDE_MODULATOR_SELECT} cca_mode_e;

   // Decode a module mode register into its operating mode
   function automatic cca_mode_e cc_mode(input logic [7:0] m);
      cca_mode_e r;
      r = MODE_OFF;
      if ((m[MM_RISING_CAPTURE_ENABLE] | m[MM_FALLING_CAPTURE_ENABLE]) && !m[MM_MAT] && !m[MM_TOG] && !m[MM_PWM]) begin
         r = MODE_CAPTURE;
      end else if (m[MM_COMPARATOR_ENABLE] && !m[MM_RISING_CAPTURE_ENABLE] && !m[MM_FALLING_CAPTURE_ENABLE]) begin
         if (m[MM_TOG] && m[MM_PWM]) begin
            r = MODE_FREQ;
         end else if (m[MM_PWM]) begin
            r = m[MM_WIDE] ? MODE_WIDE_MODULATOR_SELECT : MODE_PWM8;
         end else if (m[MM_MAT] && m[MM_TOG]) begin
            r = MODE_HSO;
         end else if (m[MM_MAT]) begin
            r = MODE_SWTIMER;
         end
      end
      return r;
   endfunction : cc_mode

endpackage : cca_pkg

// ### cca_cc_unit.sv
// Purpose: One capture/compare module: mode register, 16-bit register, pin sync, match.
// Assumes: count_step pulses in the cycle after the counter took a new value.
// Notes:   Frequency output and both modulator modes decode but drive nothing here.

`timescale 1ns/1ps

module cca_cc_unit (
   input wire logic clk,
   input wire logic reset,
   input wire logic pin_raw,
   input wire logic [15:0] count,
   input wire logic count_step,
   input wire logic wr_mode,
   input wire logic wr_low,
   input wire logic wr_high,
   input wire logic [7:0] wdata,
   output logic [7:0] mode_q,
   output logic [15:0] ccr_q,
   output logic event_q,
   output logic out_q,
   output logic pin_level
);

   // ----------------------------------------------------------------
   // Pin synchroniser and edge detect
   // ----------------------------------------------------------------
   logic s1_q, s2_q, s3_q; // Two-flop sync plus history flop
   logic rise, fall, cap_hit, match;
   cca_pkg::cca_mode_e mode;

   // Pin comes from outside; only s2/s3 feed logic, so a level must hold two clocks
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign pin_level = s2_q; // Live level for edge identification
   assign rise = s2_q & ~s3_q;
   assign fall = ~s2_q & s3_q;
   assign mode = cca_pkg::cc_mode(mode_q);
   assign cap_hit = (mode == cca_pkg::MODE_CAPTURE) &&
      ((rise && mode_q[cca_pkg::MM_RISING_CAPTURE_ENABLE]) || (fall && mode_q[cca_pkg::MM_FALLING_CAPTURE_ENABLE]));
   // Compare only when the count has just moved, so one value gives one event
   assign match = count_step && (count == ccr_q);

   // ----------------------------------------------------------------
   // Mode register with comparator enable side effects
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mode_q <= 8'h00;
      end else begin
         if (wr_mode) begin
            mode_q <= wdata;
         end
         // Low byte write disarms, high byte write arms
         if (wr_low) begin
            mode_q[cca_pkg::MM_COMPARATOR_ENABLE] <= 1'b0;
         end else if (wr_high) begin
            mode_q[cca_pkg::MM_COMPARATOR_ENABLE] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Capture/compare register
   // ----------------------------------------------------------------
   // Software writes win over a capture in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ccr_q <= 16'h0000;
      end else if (wr_low || wr_high) begin
         if (wr_low) begin
            ccr_q[7:0] <= wdata;
         end
         if (wr_high) begin
            ccr_q[15:8] <= wdata;
         end
      end else if (cap_hit) begin
         ccr_q <= count;
      end
   end

   // Event pulse and high-speed output toggle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         event_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         event_q <= cap_hit || (match && (mode == cca_pkg::MODE_SWTIMER ||
            mode == cca_pkg::MODE_HSO));
         if (match && mode == cca_pkg::MODE_HSO) begin
            out_q <= ~out_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_capture_load;
      @(posedge clk) disable iff (reset)
      (cap_hit && !wr_low && !wr_high) |=> (ccr_q == $past(count)) && event_q;
   endproperty
   a_capture_load: assert property (p_capture_load) else $error("capture lost");

   property p_comparator_enable_arm;
      @(posedge clk) disable iff (reset)
      (wr_high && !wr_low) |=> mode_q[cca_pkg::MM_COMPARATOR_ENABLE];
   endproperty
   a_comparator_enable_arm: assert property (p_comparator_enable_arm) else $error("high write did not arm");

   property p_hso_toggle;
      @(posedge clk) disable iff (reset)
      (match && mode == cca_pkg::MODE_HSO) |=> (out_q != $past(out_q)) && event_q;
   endproperty
   a_hso_toggle: assert property (p_hso_toggle) else $error("output did not toggle");

endmodule : cca_cc_unit

// ### cca_pins_model.sv
// Purpose: Far-side model of the pins that feed the counter array.
// Assumes: Bench sets pin levels as requests; model drives them on clock edges.
// Notes:   Levels change only on an edge and are held until the bench moves them.
`timescale 1ns/1ps
module cca_pins_model (
   input wire logic clk,
   input wire logic [6:0] pin_req,
   output logic [6:0] pins
);
   // Each level is re-launched on an edge, never mid-cycle; the bench holds
   // levels for at least two clocks, so two-clock validity is always met
   always_ff @(posedge clk) begin
      pins <= pin_req;
   end
endmodule : cca_pins_model

// ### cca_counter_array_tb.sv
// Purpose: Self-checking bench for the counter array.
// Assumes: APB master waits on pready; timer 0 input held low.
// Notes:   Counter is stopped while loaded so captured values are exact.
`timescale 1ns/1ps
module cca_counter_array_tb;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, rd;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, err, irq;
   logic [6:0] pin_req = 7'h00, pins;
   logic [4:0] module_out;
   logic cpu_idle = 0; // Processor idle level, same clock domain
   int bad_count = 0, comparisons = 0;
   always #2 clk = ~clk;
   cca_pins_model PM (.clk(clk), .pin_req(pin_req), .pins(pins));
   cca_counter_array DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_idle(cpu_idle), .timer0_overflow(1'b0),
      .external_count_input(pins[5]), .external_oscillator(pins[6]),
      .module_pin(pins[4:0]), .module_out(module_out), .irq(irq));
   // One APB transfer; request held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Compare and count
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(rd, e);
   endtask : rchk
   // Reset value and an unmapped read
   task automatic s_reset;
      apb(1'b1, 8'h00, 8'h77);
      rchk(8'h08, 8'h40);
      rchk(8'hfc, 8'h00);
      chk({7'h0, err}, 8'h01);
   endtask : s_reset
   // Stopped counter loaded, rising edge captured into module 0
   task automatic s_capture;
      apb(1'b1, 8'h08, 8'h00);
      apb(1'b1, 8'h00, 8'h34);
      apb(1'b1, 8'h04, 8'h12);
      apb(1'b1, 8'h20, 8'h20);
      pin_req[0] <= 1'b1;
      repeat (8) @(posedge clk);
      rchk(8'h0c, 8'h01);
      rchk(8'h40, 8'h34);
      rchk(8'h60, 8'h12);
      rchk(8'h00, 8'h34);
      rchk(8'h04, 8'h12);
   endtask : s_capture
   // High-speed output on module 1 armed by the high-byte write
   task automatic s_match;
      apb(1'b1, 8'h24, 8'h0c);
      apb(1'b1, 8'h44, 8'h10);
      apb(1'b1, 8'h64, 8'h12);
      apb(1'b1, 8'h00, 8'h0e);
      apb(1'b1, 8'h08, 8'h08);
      apb(1'b1, 8'h0c, 8'h40);
      repeat (20) @(posedge clk);
      rchk(8'h0c, 8'h42);
      chk({7'h0, module_out[1]}, 8'h01);
   endtask : s_match
   // Wrap to zero sets the overflow flag and raises the request
   task automatic s_overflow;
      apb(1'b1, 8'h0c, 8'h00);
      apb(1'b1, 8'h00, 8'hfe);
      apb(1'b1, 8'h04, 8'hff);
      apb(1'b1, 8'h10, 8'h03);
      apb(1'b1, 8'h08, 8'h09);
      apb(1'b1, 8'h0c, 8'h40);
      repeat (10) @(posedge clk);
      rchk(8'h0c, 8'hc0);
      chk({7'h0, irq}, 8'h01);
      apb(1'b1, 8'h0c, 8'h00);
      repeat (3) @(posedge clk);
      chk({7'h0, irq}, 8'h00);
   endtask : s_overflow
   // Idle with suspend holds the count; suspend cleared lets it run on
   task automatic s_idle;
      cpu_idle <= 1'b1;
      apb(1'b1, 8'h08, 8'h88);
      apb(1'b1, 8'h00, 8'h50);
      apb(1'b1, 8'h04, 8'h00);
      apb(1'b1, 8'h0c, 8'h40);
      repeat (4) @(posedge clk);
      rchk(8'h00, 8'h50);
      apb(1'b1, 8'h08, 8'h08);
      rchk(8'h00, 8'h52);
   endtask : s_idle
   // External count input falling edges, then oscillator divided by eight
   task automatic s_sources;
      apb(1'b1, 8'h0c, 8'h00);
      apb(1'b1, 8'h00, 8'h00);
      apb(1'b1, 8'h08, 8'h06);
      apb(1'b1, 8'h0c, 8'h40);
      repeat (3) begin
         pin_req[5] <= 1'b1;
         repeat (4) @(posedge clk);
         pin_req[5] <= 1'b0;
         repeat (4) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      rchk(8'h00, 8'h03);
      apb(1'b1, 8'h08, 8'h0a);
      repeat (16) begin
         pin_req[6] <= ~pin_req[6];
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      rchk(8'h00, 8'h04);
   endtask : s_sources
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      s_reset();
      s_capture();
      s_match();
      s_overflow();
      s_idle();
      s_sources();
      wrap_up();
   end
   // Hang guard, far beyond the few hundred cycles the tests take
   initial begin
      #20000;
      bad_count++;
      wrap_up();
   end
endmodule : cca_counter_array_tb
